// [design/eefr_pkg.sv]
package eefr_pkg;

    // Register bus
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // Register offsets (word index on the plain port)
    localparam logic [7:0] OFS_EV3_SRC = 8'h00;
    localparam logic [7:0] OFS_EV3_KIND = 8'h01;
    localparam logic [7:0] OFS_EV4_SRC = 8'h02;
    localparam logic [7:0] OFS_EV4_KIND = 8'h03;
    localparam logic [7:0] OFS_EV5_SRC = 8'h04;
    localparam logic [7:0] OFS_EV5_KIND = 8'h05;
    localparam logic [7:0] OFS_CLR_SRC = 8'h06;
    localparam logic [7:0] OFS_TRIP_STS = 8'h07;
    localparam logic [7:0] OFS_LIVE_STS = 8'h08;
    localparam logic [7:0] OFS_INT_STS = 8'h09;
    localparam logic [7:0] OFS_INT_CLR = 8'h0A;
    localparam logic [7:0] OFS_INT_ENA = 8'h0B;

    // Number of events handled here
    localparam int NUM_EV = 3;

    // Source codes
    localparam logic [15:0] SRC_FALSE = 16'h0000;
    localparam logic [15:0] SRC_TRUE = 16'h0001;
    localparam logic [15:0] SRC_DI_BASE = 16'h0002;
    localparam logic [15:0] SRC_DI_N = 16'h0004;
    localparam logic [15:0] SRC_DIO_BASE = 16'h000A;
    localparam logic [15:0] SRC_DIO_N = 16'h0002;
    localparam logic [15:0] SRC_TF_BASE = 16'h0012;
    localparam logic [15:0] SRC_TF_N = 16'h0003;
    localparam logic [15:0] SRC_SUP_BASE = 16'h0018;
    localparam logic [15:0] SRC_SUP_N = 16'h0006;
    // Bit pointer choice: flag bit set, index in the low bits
    localparam int SRC_PTR_FLAG = 15;
    localparam int PTR_W = 6;
    localparam int OTHER_W = 64;

    // Event kind encodings
    localparam logic [15:0] KIND_FAULT = 16'h0000;
    localparam logic [15:0] KIND_WARN = 16'h0001;

    // Reset values
    localparam logic [15:0] EV_SRC_RST = SRC_TRUE;
    localparam logic [15:0] EV_KIND_RST = KIND_FAULT;
    localparam logic [15:0] CLR_SRC_RST = SRC_FALSE;

    // Interrupt status layout
    localparam int IRQ_W = 7;
    localparam int IRQ_TRIP_LSB = 0;
    localparam int IRQ_WARN_LSB = 3;
    localparam int IRQ_RESET_BIT = 6;
    localparam logic [IRQ_W-1:0] IRQ_RST = 7'h00;

    // Trip status layout
    localparam int TRIP_LSB = 0;
    localparam int WARN_LSB = 4;

    // Live status layout
    localparam int LIVE_EV_LSB = 0;
    localparam int LIVE_CLR_BIT = 4;

    typedef struct packed {
        logic [OTHER_W-1:0] other;
        logic [5:0] superv;
        logic [2:0] timed;
        logic [1:0] dio;
        logic [3:0] di;
    } eefr_src_bus_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } eefr_bus_req_t;

    typedef struct packed {
        logic prev;
    } eefr_rise_st_t;

    typedef struct packed {
        logic [NUM_EV-1:0][15:0] ev_src;
        logic [NUM_EV-1:0][15:0] ev_kind;
        logic [15:0] clr_src;
        logic [NUM_EV-1:0] trip;
        logic [NUM_EV-1:0] warn;
        logic [IRQ_W-1:0] int_sts;
        logic [IRQ_W-1:0] int_ena;
        logic irq;
        logic [DATA_W-1:0] rdata;
    } eefr_st_t;

endpackage

// [design/eefr_src_sel.sv]
`timescale 1ns/1ps
module eefr_src_sel
    import eefr_pkg::*;
(
    input wire logic [15:0] code,
    input wire eefr_src_bus_t src,
    output logic bit_out
);

    logic [15:0] rel;

    always_comb
    begin
        rel = 16'h0000;
        bit_out = 1'b0;
        if (code[SRC_PTR_FLAG])
        begin
            bit_out = src.other[code[PTR_W-1:0]];
        end
        else if (code == SRC_FALSE)
        begin
            bit_out = 1'b0;
        end
        else if (code == SRC_TRUE)
        begin
            bit_out = 1'b1;
        end
        else if (code >= SRC_DI_BASE && code < SRC_DI_BASE + SRC_DI_N)
        begin
            rel = code - SRC_DI_BASE;
            bit_out = src.di[rel[1:0]];
        end
        else if (code >= SRC_DIO_BASE && code < SRC_DIO_BASE + SRC_DIO_N)
        begin
            rel = code - SRC_DIO_BASE;
            bit_out = src.dio[rel[0]];
        end
        else if (code >= SRC_TF_BASE && code < SRC_TF_BASE + SRC_TF_N)
        begin
            rel = code - SRC_TF_BASE;
            bit_out = src.timed[rel[1:0]];
        end
        else if (code >= SRC_SUP_BASE && code < SRC_SUP_BASE + SRC_SUP_N)
        begin
            rel = code - SRC_SUP_BASE;
            bit_out = src.superv[rel[2:0]];
        end
    end

endmodule

// [design/eefr_rise.sv]
`timescale 1ns/1ps
module eefr_rise
    import eefr_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic level,
    output logic pulse
);

    eefr_rise_st_t s_ff;
    eefr_rise_st_t nxt_s;

    always_comb
    begin
        nxt_s = s_ff;
        nxt_s.prev = level;
    end

    // Only a low to high step counts; a steady high repeats nothing
    assign pulse = level & ~s_ff.prev;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            s_ff <= '0;
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end

endmodule

// [design/eefr_top.sv]
`timescale 1ns/1ps
module eefr_top
    import eefr_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] bus_addr,
    input wire logic [DATA_W-1:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [DATA_W-1:0] bus_rdata,
    input wire logic [3:0] digital_input_status,
    input wire logic [1:0] bidir_pin_status,
    input wire logic [2:0] timed_func_status,
    input wire logic [5:0] supervision_status,
    input wire logic [OTHER_W-1:0] other_status,
    input wire logic fieldbus_clear_req,
    output logic [NUM_EV-1:0] fault_trip,
    output logic [NUM_EV-1:0] warning,
    output logic irq
);

    eefr_st_t s_ff;
    eefr_st_t nxt_s;
    eefr_src_bus_t src;
    eefr_bus_req_t req;
    logic [NUM_EV-1:0] ev_level;
    logic [NUM_EV-1:0] ev_active;
    logic clr_level;
    logic clr_rise;
    logic clear_req;
    logic [NUM_EV-1:0] trip_set;
    logic [NUM_EV-1:0] warn_rise;
    logic [IRQ_W-1:0] int_evt;

    // Maps a register offset to an event number, or NUM_EV if none
    function automatic logic [1:0] ev_of(input logic [ADDR_W-1:0] a);
        logic [1:0] r;
        r = 2'(NUM_EV);
        case (a)
            OFS_EV3_SRC, OFS_EV3_KIND: r = 2'd0;
            OFS_EV4_SRC, OFS_EV4_KIND: r = 2'd1;
            OFS_EV5_SRC, OFS_EV5_KIND: r = 2'd2;
            default: r = 2'(NUM_EV);
        endcase
        return r;
    endfunction

    // True for the kind half of an event register pair
    function automatic logic is_kind(input logic [ADDR_W-1:0] a);
        return (a == OFS_EV3_KIND) || (a == OFS_EV4_KIND) ||
            (a == OFS_EV5_KIND);
    endfunction

    assign src.di = digital_input_status;
    assign src.dio = bidir_pin_status;
    assign src.timed = timed_func_status;
    assign src.superv = supervision_status;
    assign src.other = other_status;

    assign req.addr = bus_addr;
    assign req.wdata = bus_wdata;
    assign req.wr = bus_wr;
    assign req.rd = bus_rd;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_EV; gi = gi + 1)
        begin : g_ev
            eefr_src_sel u_sel
            (
                .code(s_ff.ev_src[gi]),
                .src(src),
                .bit_out(ev_level[gi])
            );
            // Event source reads true while inactive
            assign ev_active[gi] = ~ev_level[gi];
        end
    endgenerate

    eefr_src_sel u_clr_sel
    (
        .code(s_ff.clr_src),
        .src(src),
        .bit_out(clr_level)
    );

    eefr_rise u_clr_rise
    (
        .mclk(mclk),
        .rst(rst),
        .level(clr_level),
        .pulse(clr_rise)
    );

    // Fieldbus path bypasses the source selector
    assign clear_req = clr_rise | fieldbus_clear_req;

    always_comb
    begin
        logic [1:0] ev;
        ev = 2'd0;
        nxt_s = s_ff;
        trip_set = '0;
        warn_rise = '0;
        int_evt = '0;

        // Register writes
        if (req.wr)
        begin
            ev = ev_of(req.addr);
            if (ev < 2'(NUM_EV))
            begin
                if (is_kind(req.addr))
                begin
                    nxt_s.ev_kind[ev] = req.wdata;
                end
                else
                begin
                    nxt_s.ev_src[ev] = req.wdata;
                end
            end
            else if (req.addr == OFS_CLR_SRC)
            begin
                nxt_s.clr_src = req.wdata;
            end
            else if (req.addr == OFS_INT_ENA)
            begin
                nxt_s.int_ena = req.wdata[IRQ_W-1:0];
            end
        end

        // Trip and warning per event
        for (int i = 0; i < NUM_EV; i++)
        begin
            if (s_ff.ev_kind[i] == KIND_WARN)
            begin
                nxt_s.warn[i] = ev_active[i];
            end
            else
            begin
                nxt_s.warn[i] = 1'b0;
                trip_set[i] = ev_active[i];
            end
            warn_rise[i] = nxt_s.warn[i] & ~s_ff.warn[i];
            if (trip_set[i])
            begin
                nxt_s.trip[i] = 1'b1;
            end
            else if (clear_req && !ev_active[i])
            begin
                nxt_s.trip[i] = 1'b0;
            end
        end

        // Sticky interrupt status; new events win over a clear
        int_evt[IRQ_TRIP_LSB +: NUM_EV] = trip_set & ~s_ff.trip;
        int_evt[IRQ_WARN_LSB +: NUM_EV] = warn_rise;
        int_evt[IRQ_RESET_BIT] = clear_req;
        if (req.wr && req.addr == OFS_INT_CLR)
        begin
            nxt_s.int_sts = s_ff.int_sts & ~req.wdata[IRQ_W-1:0];
        end
        nxt_s.int_sts = nxt_s.int_sts | int_evt;
        nxt_s.irq = |(nxt_s.int_sts & nxt_s.int_ena);

        // Read data stand in the cycle after the strobe only
        nxt_s.rdata = '0;
        if (req.rd)
        begin
            ev = ev_of(req.addr);
            if (ev < 2'(NUM_EV))
            begin
                if (is_kind(req.addr))
                begin
                    nxt_s.rdata = s_ff.ev_kind[ev];
                end
                else
                begin
                    nxt_s.rdata = s_ff.ev_src[ev];
                end
            end
            else
            begin
                case (req.addr)
                    OFS_CLR_SRC: nxt_s.rdata = s_ff.clr_src;
                    OFS_TRIP_STS:
                    begin
                        nxt_s.rdata[TRIP_LSB +: NUM_EV] = s_ff.trip;
                        nxt_s.rdata[WARN_LSB +: NUM_EV] = s_ff.warn;
                    end
                    OFS_LIVE_STS:
                    begin
                        nxt_s.rdata[LIVE_EV_LSB +: NUM_EV] = ev_active;
                        nxt_s.rdata[LIVE_CLR_BIT] = clr_level;
                    end
                    OFS_INT_STS: nxt_s.rdata[IRQ_W-1:0] = s_ff.int_sts;
                    OFS_INT_ENA: nxt_s.rdata[IRQ_W-1:0] = s_ff.int_ena;
                    default: nxt_s.rdata = '0;
                endcase
            end
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            s_ff.ev_src <= {NUM_EV{EV_SRC_RST}};
            s_ff.ev_kind <= {NUM_EV{EV_KIND_RST}};
            s_ff.clr_src <= CLR_SRC_RST;
            s_ff.trip <= '0;
            s_ff.warn <= '0;
            s_ff.int_sts <= IRQ_RST;
            s_ff.int_ena <= IRQ_RST;
            s_ff.irq <= 1'b0;
            s_ff.rdata <= '0;
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end

    assign bus_rdata = s_ff.rdata;
    assign fault_trip = s_ff.trip;
    assign warning = s_ff.warn;
    assign irq = s_ff.irq;

endmodule

// [dv/eefr_monitor.sv]
`timescale 1ns/1ps
module eefr_monitor
    import eefr_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] bus_addr,
    input wire logic [DATA_W-1:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [DATA_W-1:0] bus_rdata,
    input wire logic fieldbus_clear_req,
    input wire logic [NUM_EV-1:0] fault_trip,
    input wire logic [NUM_EV-1:0] warning,
    input wire logic irq
);
    logic [2:0] kw;
    logic [15:0] cs;
    logic [6:0] ie;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // Shadows of the kind, clear source and enable registers
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            kw <= '0;
            cs <= CLR_SRC_RST;
            ie <= IRQ_RST;
        end
        else if (bus_wr)
        begin
            if (bus_addr == OFS_EV3_KIND) kw[0] <= bus_wdata == KIND_WARN;
            if (bus_addr == OFS_EV4_KIND) kw[1] <= bus_wdata == KIND_WARN;
            if (bus_addr == OFS_EV5_KIND) kw[2] <= bus_wdata == KIND_WARN;
            if (bus_addr == OFS_CLR_SRC) cs <= bus_wdata;
            if (bus_addr == OFS_INT_ENA) ie <= bus_wdata[6:0];
        end
    end
    a_rd_slot: assert property (bus_rdata != '0 |-> $past(bus_rd))
        else $error("read data outside its slot");
    a_unmapped_zero: assert property ($past(bus_rd)
        && $past(bus_addr) > OFS_INT_ENA |-> bus_rdata == '0)
        else $error("unmapped read not zero");
    a_reset_quiet: assert property ($fell(rst) |-> fault_trip == '0
        && warning == '0 && !irq) else $error("outputs busy after reset");
    a_trip_fault_kind: assert property (
        (fault_trip & ~$past(fault_trip) & $past(kw)) == '0)
        else $error("trip raised by warning kind");
    a_warn_only_kind: assert property ((warning & ~$past(kw)) == '0)
        else $error("warning raised by fault kind");
    a_trip_clear_cause: assert property (
        (~fault_trip & $past(fault_trip)) != '0 |-> $past(fieldbus_clear_req)
        || cs != CLR_SRC_RST || $past(cs) != CLR_SRC_RST)
        else $error("trip cleared without request");
    a_irq_masked: assert property (ie == '0 && $past(ie) == '0 |-> !irq)
        else $error("irq while all masked");
    a_irq_on_trip: assert property ($rose(fault_trip[0])
        && ie[IRQ_TRIP_LSB] && $past(ie[IRQ_TRIP_LSB]) |-> irq)
        else $error("no irq on enabled trip");
    a_trip_warn_excl: assert property (
        (fault_trip & ~$past(fault_trip) & warning & ~$past(warning)) == '0)
        else $error("trip and warning rose together");
    c_trip: cover property ($rose(fault_trip[0]));
    c_warn: cover property ($rose(warning[1]));
    c_irq: cover property ($rose(irq));
endmodule
bind eefr_top eefr_monitor eefr_monitor_inst (.mclk, .rst, .bus_addr,
    .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .fieldbus_clear_req,
    .fault_trip, .warning, .irq);

// [dv/eefr_status_model.sv]
`timescale 1ns/1ps
module eefr_status_model
    import eefr_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic hold,
    input wire logic [78:0] next_val,
    output eefr_src_bus_t status
);
    // Status words move only on edges; hold models a slow source
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            status <= '1;
        else if (!hold)
            status <= next_val;
    end
endmodule

// [dv/tb_eefr_top.sv]
`timescale 1ns/1ps
module tb_eefr_top
    import eefr_pkg::*;
;
    logic mclk, rst, bus_wr, bus_rd, fb, hold, irq, lvl, req, m_prev;
    logic [ADDR_W-1:0] bus_addr;
    logic [DATA_W-1:0] bus_wdata, bus_rdata, m_cs, m_rd;
    logic [2:0] fault_trip, warning, mt, mw, nt, nw, act;
    logic [2:0][15:0] m_src, m_kind;
    logic [6:0] ms, me;
    logic [78:0] nv;
    logic [31:0] rs;
    eefr_src_bus_t st;
    int miscompares, check_count;
    int codes[$] = '{0, 1, 2, 3, 4, 5, 10, 11, 18, 19, 20, 24, 25, 26, 27,
        28, 29, 32'h8000, 32'h8025};
    eefr_status_model eefr_status_model_inst (.mclk, .rst, .hold,
        .next_val(nv), .status(st));
    eefr_top eefr_top_inst (.mclk, .rst, .bus_addr, .bus_wdata, .bus_wr,
        .bus_rd, .bus_rdata, .digital_input_status(st.di),
        .bidir_pin_status(st.dio), .timed_func_status(st.timed),
        .supervision_status(st.superv), .other_status(st.other),
        .fieldbus_clear_req(fb), .fault_trip, .warning, .irq);
    initial
    begin
        mclk = 0;
        forever #50 mclk = ~mclk;
    end
    function automatic logic [31:0] xs(logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    function automatic logic sel(logic [15:0] c);
        if (c[SRC_PTR_FLAG]) return st.other[c[PTR_W-1:0]];
        if (c == 1) return 1'b1;
        if (c >= 2 && c <= 5) return st.di[c-2];
        if (c == 10 || c == 11) return st.dio[c-10];
        if (c >= 18 && c <= 20) return st.timed[c-18];
        if (c >= 24 && c <= 29) return st.superv[c-24];
        return 1'b0;
    endfunction
    function automatic logic [15:0] rv(logic [7:0] a);
        if (a <= OFS_EV5_KIND) return a[0] ? m_kind[a[2:1]] : m_src[a[2:1]];
        case (a)
            OFS_CLR_SRC: return m_cs;
            OFS_TRIP_STS: return {9'h0, mw, 1'b0, mt};
            OFS_LIVE_STS: return {11'h0, lvl, 1'b0, act};
            OFS_INT_STS: return {9'h0, ms};
            OFS_INT_ENA: return {9'h0, me};
            default: return '0;
        endcase
    endfunction
    // Reference model, evaluated on pre-edge inputs
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            m_src = {3{EV_SRC_RST}};
            m_kind = {3{EV_KIND_RST}};
            m_cs = CLR_SRC_RST;
            {mt, mw, ms, me, m_prev, m_rd} = '0;
        end
        else
        begin
            for (int i = 0; i < 3; i++) act[i] = !sel(m_src[i]);
            lvl = sel(m_cs);
            req = fb || (lvl && !m_prev);
            m_rd = bus_rd ? rv(bus_addr) : '0;
            for (int i = 0; i < 3; i++)
            begin
                nw[i] = act[i] && m_kind[i] == KIND_WARN;
                nt[i] = mt[i];
                if (req && !act[i]) nt[i] = 1'b0;
                if (act[i] && m_kind[i] != KIND_WARN) nt[i] = 1'b1;
            end
            if (bus_wr && bus_addr == OFS_INT_CLR) ms &= ~bus_wdata[6:0];
            ms |= {req, nw & ~mw, nt & ~mt};
            {mt, mw, m_prev} = {nt, nw, lvl};
            if (bus_wr && bus_addr <= OFS_EV5_KIND && bus_addr[0])
                m_kind[bus_addr[2:1]] = bus_wdata;
            if (bus_wr && bus_addr <= OFS_EV5_KIND && !bus_addr[0])
                m_src[bus_addr[2:1]] = bus_wdata;
            if (bus_wr && bus_addr == OFS_CLR_SRC) m_cs = bus_wdata;
            if (bus_wr && bus_addr == OFS_INT_ENA) me = bus_wdata[6:0];
        end
    end
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        check_count++;
        if (g !== e)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    always @(negedge mclk)
    begin
        if (!rst)
        begin
            chk("fault_trip", mt, fault_trip);
            chk("warning", mw, warning);
            chk("irq", |(ms & me), irq);
            chk("bus_rdata", m_rd, bus_rdata);
        end
    end
    task automatic bus(logic w, logic [7:0] a, logic [15:0] d);
        @(posedge mclk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= w;
        bus_rd <= !w;
        @(posedge mclk);
        bus_wr <= 1'b0;
        bus_rd <= 1'b0;
    endtask
    task automatic run(int n);
        repeat (n)
        begin
            @(posedge mclk);
            rs = xs(rs);
            nv <= {rs, rs ^ 32'h5a5a_5a5a, rs[14:0]};
            fb <= rs[7:0] == 8'h00;
            hold <= rs[31];
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        {rst, bus_wr, bus_rd, fb, hold, bus_addr, bus_wdata} = '1;
        {bus_wr, bus_rd, fb, hold} = '0;
        nv = '1;
        rs = 32'hb45f;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        for (int a = 0; a < 16; a++) bus(0, a[7:0], '0);
        bus(1, OFS_INT_ENA, 16'h007f);
        bus(1, OFS_EV4_KIND, KIND_WARN);
        bus(1, OFS_EV5_KIND, 16'h0002);
        foreach (codes[i])
        begin
            bus(1, OFS_EV3_SRC, codes[i][15:0]);
            bus(1, OFS_EV4_SRC, codes[(i+3)%19][15:0]);
            bus(1, OFS_EV5_SRC, codes[(i+7)%19][15:0]);
            bus(1, OFS_CLR_SRC, codes[(i+1)%19][15:0]);
            run(60);
            bus(0, OFS_INT_STS, '0);
            bus(1, OFS_INT_CLR, 16'h007f);
            bus(0, OFS_TRIP_STS, '0);
            bus(0, OFS_LIVE_STS, '0);
        end
        bus(1, OFS_INT_ENA, 16'h0000);
        run(50);
        end_of_test;
    end
    initial
    begin
        #1_000_000;
        miscompares++;
        end_of_test;
    end
endmodule
